/* File: hw/mnp_host.sv */
`timescale 1ns/1ps
`include "mnp_regs.svh"

module mnp_host (
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   mnp_if.host              link,
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic [10:0] req_addr,
   input  wire logic [7:0]  req_wdata,
   input  wire logic        ddr_valid,
   input  wire logic [7:0]  ddr_value,
   input  wire logic [7:0]  port_value,
   input  wire logic        port_drive,
   output logic             req_ready,
   output logic             rsp_valid,
   output logic      [7:0]  rsp_data,
   output logic             power_fail_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   mnp_pkg::mnp_host_s h_reg;
   mnp_pkg::mnp_host_s h_next;

   logic       step_done;
   logic       last_byte;
   logic [7:0] cmd_byte;

   assign step_done = (h_reg.cnt == 4'(`MNP_STEP_CYC - 1));
   assign last_byte = h_reg.is_ddr | (h_reg.byte_idx == `MNP_BYTE_DATA);
   // read flag in bit 7, upper address in low bits
   assign cmd_byte  = {h_reg.is_read, 4'h0,
                       h_reg.addr[`MNP_ADDR_MSB:`MNP_ADDR_HI_LSB]};

   ////////////////////////////////////////////////////////////////////////////
   // sequencer: setup, clock high, hold, per byte

   always_comb begin
      h_next           = h_reg;
      h_next.rsp_valid = 1'b0;
      h_next.irq       = link.power_fail_out;
      h_next.cnt       = step_done ? `MNP_CNT_RST : 4'(h_reg.cnt + 4'h1);
      case (h_reg.state)
         mnp_pkg::MNP_H_IDLE: begin
            h_next.cnt     = `MNP_CNT_RST;
            h_next.mem_sel = 1'b1;
            h_next.xclk    = 1'b0;
            h_next.bus_out = port_value;
            h_next.bus_oe  = port_drive;
            h_next.ready   = 1'b1;
            h_next.byte_idx = `MNP_BYTE_CMD;
            if (ddr_valid || req_valid) begin
               h_next.is_ddr  = ddr_valid;
               h_next.is_read = ~ddr_valid & ~req_write;
               h_next.addr    = req_addr;
               h_next.wdata   = ddr_valid ? ddr_value : req_wdata;
               h_next.ready   = 1'b0;
               h_next.state   = mnp_pkg::MNP_H_SETUP;
               // select low for array, high for direction register
               h_next.mem_sel = ddr_valid;
               h_next.bus_out = ddr_valid ? ddr_value :
                                {~req_write, 4'h0,
                                 req_addr[`MNP_ADDR_MSB:`MNP_ADDR_HI_LSB]};
               h_next.bus_oe  = 1'b1;
            end
         end
         mnp_pkg::MNP_H_SETUP: begin
            if (step_done) begin
               // clock rises only after a full setup step on a steady bus
               h_next.xclk  = 1'b1;
               h_next.state = mnp_pkg::MNP_H_HIGH;
            end
         end
         mnp_pkg::MNP_H_HIGH: begin
            if (step_done) begin
               if (h_reg.is_read && h_reg.byte_idx == `MNP_BYTE_DATA) begin
                  h_next.rsp_data = link.host_side_port_in;
               end
               h_next.xclk  = 1'b0;
               h_next.state = mnp_pkg::MNP_H_HOLD;
            end
         end
         mnp_pkg::MNP_H_HOLD: begin
            if (step_done) begin
               if (last_byte) begin
                  h_next.rsp_valid = h_reg.is_read;
                  h_next.state     = mnp_pkg::MNP_H_IDLE;
                  h_next.mem_sel   = 1'b1;
                  h_next.ready     = 1'b1;
                  h_next.bus_out   = port_value;
                  h_next.bus_oe    = port_drive;
               end else begin
                  h_next.byte_idx = 2'(h_reg.byte_idx + 2'h1);
                  h_next.state    = mnp_pkg::MNP_H_SETUP;
                  h_next.bus_oe   = ~(h_reg.is_read &&
                                      h_reg.byte_idx == `MNP_BYTE_ADDR);
                  h_next.bus_out  = (h_reg.byte_idx == `MNP_BYTE_CMD) ?
                                    h_reg.addr[`MNP_ADDR_LO_MSB:0] : h_reg.wdata;
               end
            end
         end
         default: begin
            h_next.state = mnp_pkg::MNP_H_IDLE;
         end
      endcase
      if (h_reg.state == mnp_pkg::MNP_H_SETUP && h_reg.byte_idx == `MNP_BYTE_CMD
          && !h_reg.is_ddr) begin
         h_next.bus_out = cmd_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         h_reg.state     <= mnp_pkg::MNP_H_IDLE;
         h_reg.byte_idx  <= `MNP_BYTE_CMD;
         h_reg.is_read   <= 1'b0;
         h_reg.is_ddr    <= 1'b0;
         h_reg.addr      <= `MNP_ADDR_RST;
         h_reg.wdata     <= `MNP_BYTE_RST;
         h_reg.cnt       <= `MNP_CNT_RST;
         h_reg.mem_sel   <= 1'b1;
         h_reg.xclk      <= 1'b0;
         h_reg.bus_out   <= `MNP_BYTE_RST;
         h_reg.bus_oe    <= 1'b0;
         h_reg.ready     <= 1'b0;
         h_reg.rsp_valid <= 1'b0;
         h_reg.rsp_data  <= `MNP_BYTE_RST;
         h_reg.irq       <= 1'b0;
      end else begin
         h_reg <= h_next;
      end
   end

   // outputs from flops
   assign link.mem_sel    = h_reg.mem_sel;
   assign link.xfer_clk   = h_reg.xclk;
   assign link.port_h_out = h_reg.bus_out;
   assign link.port_h_oe  = h_reg.bus_oe;
   assign req_ready       = h_reg.ready;
   assign rsp_valid       = h_reg.rsp_valid;
   assign rsp_data        = h_reg.rsp_data;
   assign power_fail_irq  = h_reg.irq;

endmodule

/* File: hw/mnp_regs.svh */
`ifndef MNP_REGS_SVH
`define MNP_REGS_SVH

// first byte layout
`define MNP_RW_BIT       7
`define MNP_HI_ADDR_MSB  2
`define MNP_HI_ADDR_LSB  0
`define MNP_RW_READ      1'b1
// address split
`define MNP_ADDR_MSB     10
`define MNP_ADDR_HI_LSB  8
`define MNP_ADDR_LO_MSB  7
`define MNP_MEM_DEPTH    2048
// reset and idle values
`define MNP_DDR_RST      8'hff
`define MNP_BYTE_RST     8'h00
`define MNP_BUS_PULLUP   8'hff
`define MNP_ALL_DRIVE    8'hff
`define MNP_ADDR_RST     11'h000
// supply monitor, millivolts
`define MNP_NOM_MV       13'h1388
`define MNP_TRIP5_MV     13'h128e
`define MNP_TRIP10_MV    13'h1194
// host step timing
`define MNP_CLK_NS       4
`define MNP_STEP_NS      20
`define MNP_STEP_CYC     ((`MNP_STEP_NS + `MNP_CLK_NS - 1) / `MNP_CLK_NS)
`define MNP_CNT_RST      4'h0
// byte index of a transfer
`define MNP_BYTE_CMD     2'h0
`define MNP_BYTE_ADDR    2'h1
`define MNP_BYTE_DATA    2'h2

`endif

/* File: hw/mnp_pkg.sv */
package mnp_pkg;

   typedef enum logic [1:0] {
      MNP_STEP_CMD,
      MNP_STEP_ADDR,
      MNP_STEP_DATA
   } mnp_step_e;

   typedef enum logic [1:0] {
      MNP_H_IDLE,
      MNP_H_SETUP,
      MNP_H_HIGH,
      MNP_H_HOLD
   } mnp_hstate_e;

   typedef struct packed {
      logic        clk_q;
      mnp_step_e   step;
      logic        is_read;
      logic        drv;
      logic [10:0] addr;
      logic [7:0]  ddr;
      logic [7:0]  hold;
      logic [7:0]  po;
      logic [7:0]  po_oe;
      logic [7:0]  bus_out;
      logic        bus_oe;
      logic        pf;
   } mnp_dev_s;

   typedef struct packed {
      mnp_hstate_e state;
      logic [1:0]  byte_idx;
      logic        is_read;
      logic        is_ddr;
      logic [10:0] addr;
      logic [7:0]  wdata;
      logic [3:0]  cnt;
      logic        mem_sel;
      logic        xclk;
      logic [7:0]  bus_out;
      logic        bus_oe;
      logic        ready;
      logic        rsp_valid;
      logic [7:0]  rsp_data;
      logic        irq;
   } mnp_host_s;

endpackage

/* File: hw/mnp_if.sv */
`timescale 1ns/1ps
`include "mnp_regs.svh"

interface mnp_if;
   logic       mem_sel;
   logic       xfer_clk;
   logic [7:0] port_h_out;
   logic       port_h_oe;
   logic [7:0] port_d_out;
   logic       port_d_oe;
   logic [7:0] host_side_port_in;
   logic       power_fail_out;

   // shared bus level, device wins, pulled up when undriven
   assign host_side_port_in = port_d_oe ? port_d_out :
                              port_h_oe ? port_h_out : `MNP_BUS_PULLUP;

   modport dev (
      input  mem_sel,
      input  xfer_clk,
      input  host_side_port_in,
      output port_d_out,
      output port_d_oe,
      output power_fail_out
   );

   modport host (
      output mem_sel,
      output xfer_clk,
      output port_h_out,
      output port_h_oe,
      input  host_side_port_in,
      input  power_fail_out
   );
endinterface

/* File: hw/mnp_device.sv */
// Function
// - first byte: upper address plus command
// - second byte low address, third data
// - one shared byte bus, select and clock
// - select and clock pick array or direction
// - idle outputs follow host port pins
// - transfer outputs latched or high impedance
// - 2048 byte array, eleven address bits
// - power fail output on supply drop
// - trip level select five or ten percent
// - select held low freezes port outputs
// - select low makes clock chip enable
// - bus-only host uses three cycles
// - controller host drives select and clock
// - processor clock is gated address decode
`timescale 1ns/1ps
`include "mnp_regs.svh"

module mnp_device (
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   mnp_if.dev               link,
   input  wire logic        trip_level_select,
   input  wire logic [12:0] supply_mv,
   output logic      [7:0]  field_side_port_out,
   output logic      [7:0]  field_side_port_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // state and storage

   mnp_pkg::mnp_dev_s r_reg;
   mnp_pkg::mnp_dev_s r_next;

   // nonvolatile bytes, eleven address bits
   logic [7:0]  mem_array [0:`MNP_MEM_DEPTH-1];

   // combinational helpers
   logic        mem_we;
   logic [7:0]  mem_rdata;
   logic        clk_rise;
   logic        clk_fall;
   logic        port_idle;
   logic [7:0]  pin;
   logic [12:0] trip_mv;
   logic        rise_array;
   logic        rise_ddr;
   logic        read_done;
   logic        cmd_read;
   logic [2:0]  cmd_hi_addr;
   logic        pf_now;
   logic [7:0]  po_bit_next;
   logic [7:0]  oe_bit_next;

   ////////////////////////////////////////////////////////////////////////////
   // edge detect on the host step clock

   // inputs are synchronous to clk_sys, so one stage is enough
   assign pin       = link.host_side_port_in;
   assign clk_rise  = link.xfer_clk & ~r_reg.clk_q;
   assign clk_fall  = ~link.xfer_clk & r_reg.clk_q;
   assign mem_rdata = mem_array[r_reg.addr];

   // no transfer: select high, clock low, waiting for a first byte
   assign port_idle = link.mem_sel & ~link.xfer_clk &
                      (r_reg.step == mnp_pkg::MNP_STEP_CMD);

   // trip point from the select pin
   assign trip_mv = trip_level_select ? `MNP_TRIP10_MV : `MNP_TRIP5_MV;

   // clock rise steered by select: array step or direction write
   assign rise_array = clk_rise & ~link.mem_sel;
   assign rise_ddr   = clk_rise & link.mem_sel;

   // data step of a read ends on the following fall
   assign read_done = clk_fall & r_reg.drv;

   // first byte fields: read flag and upper address bits
   assign cmd_read    = (pin[`MNP_RW_BIT] == `MNP_RW_READ);
   assign cmd_hi_addr = pin[`MNP_HI_ADDR_MSB:`MNP_HI_ADDR_LSB];

   ////////////////////////////////////////////////////////////////////////////
   // supply monitor

   // raw comparison, no hysteresis, registered below
   assign pf_now = (supply_mv < trip_mv);

   ////////////////////////////////////////////////////////////////////////////
   // field port, one slice per pin

   // idle slices follow the host pin; busy slices hold, driven or off
   for (genvar b = 0; b < $bits(pin); b++) begin : g_field
      assign po_bit_next[b] = port_idle ? pin[b] : r_reg.hold[b];
      assign oe_bit_next[b] = port_idle | r_reg.ddr[b];
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   // transfer sequencer, port mux and supply monitor
   always_comb begin
      r_next        = r_reg;
      mem_we        = 1'b0;
      r_next.clk_q  = link.xfer_clk;

      case (r_reg.step)
         mnp_pkg::MNP_STEP_CMD: begin
            r_next.drv = 1'b0;
            if (rise_ddr) begin
               // select high: byte goes to direction register
               r_next.ddr = pin;
            end else if (rise_array) begin
               // select low: clock acts as array enable
               r_next.is_read = cmd_read;
               r_next.addr[`MNP_ADDR_MSB:`MNP_ADDR_HI_LSB] = cmd_hi_addr;
               r_next.step = mnp_pkg::MNP_STEP_ADDR;
            end
         end
         mnp_pkg::MNP_STEP_ADDR: begin
            if (link.mem_sel) begin
               // select raised mid access aborts it
               r_next.step = mnp_pkg::MNP_STEP_CMD;
            end else if (clk_rise) begin
               r_next.addr[`MNP_ADDR_LO_MSB:0] = pin;
               r_next.step = mnp_pkg::MNP_STEP_DATA;
            end
         end
         mnp_pkg::MNP_STEP_DATA: begin
            if (link.mem_sel) begin
               r_next.step = mnp_pkg::MNP_STEP_CMD;
               r_next.drv  = 1'b0;
            end else if (r_reg.is_read) begin
               // read: drive data from third rise until its fall
               if (clk_rise) begin
                  r_next.drv = 1'b1;
               end else if (read_done) begin
                  r_next.drv  = 1'b0;
                  r_next.step = mnp_pkg::MNP_STEP_CMD;
               end
            end else if (clk_rise) begin
               // write: third byte stored on its rising edge
               mem_we      = 1'b1;
               r_next.step = mnp_pkg::MNP_STEP_CMD;
            end
         end
         default: begin
            r_next.step = mnp_pkg::MNP_STEP_CMD;
            r_next.drv  = 1'b0;
         end
      endcase

      // device drives the shared bus only for read data
      r_next.bus_oe  = r_next.drv;
      r_next.bus_out = r_next.drv ? mem_rdata : `MNP_BYTE_RST;

      // port outputs: pass through when idle, else latched or off
      r_next.hold  = po_bit_next;
      r_next.po    = po_bit_next;
      r_next.po_oe = oe_bit_next;

      // supply below trip point raises power fail
      r_next.pf = pf_now;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   // all control state
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         // link tracking and sequencer
         r_reg.clk_q   <= 1'b0;
         r_reg.step    <= mnp_pkg::MNP_STEP_CMD;
         r_reg.is_read <= 1'b0;
         r_reg.drv     <= 1'b0;
         r_reg.addr    <= `MNP_ADDR_RST;
         // field port: direction register all driven
         r_reg.ddr     <= `MNP_DDR_RST;
         r_reg.hold    <= `MNP_BYTE_RST;
         r_reg.po      <= `MNP_BYTE_RST;
         r_reg.po_oe   <= `MNP_BYTE_RST;
         // shared bus released, power fail clear
         r_reg.bus_out <= `MNP_BYTE_RST;
         r_reg.bus_oe  <= 1'b0;
         r_reg.pf      <= 1'b0;
      end else begin
         r_reg <= r_next;
      end
   end

   // nonvolatile array, never cleared by reset
   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         mem_array[r_reg.addr] <= pin;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // every output taken from a flop: link side
   assign link.port_d_out      = r_reg.bus_out;
   assign link.port_d_oe       = r_reg.bus_oe;
   assign link.power_fail_out  = r_reg.pf;

   // field side, oe low means high impedance
   assign field_side_port_out  = r_reg.po;
   assign field_side_port_oe   = r_reg.po_oe;

endmodule

/* File: verif/mnp_link_monitor.sv */
`timescale 1ns/1ps
module mnp_link_monitor (
   input wire logic       clk_sys,
   input wire logic       arst_n,
   input wire logic       mem_sel,
   input wire logic       xfer_clk,
   input wire logic [7:0] port_h_out,
   input wire logic       port_h_oe,
   input wire logic [7:0] port_d_out,
   input wire logic       port_d_oe,
   input wire logic [7:0] host_side_port_in,
   input wire logic       power_fail_out
);
   logic       clk_prev_reg;
   logic [1:0] rise_cnt_reg;
   logic       rd_reg;
   logic       rise;

   ////////////////////////////////////////////////////////////////////////////
   // rise of the transfer clock, byte count within an array access
   assign rise = xfer_clk & ~clk_prev_reg;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         clk_prev_reg <= 1'b0;
         rise_cnt_reg <= 2'h0;
         rd_reg       <= 1'b0;
      end else begin
         clk_prev_reg <= xfer_clk;
         if (mem_sel) begin
            rise_cnt_reg <= 2'h0;
         end else if (rise) begin
            rise_cnt_reg <= rise_cnt_reg + 2'h1;
            if (rise_cnt_reg == 2'h0) begin
               rd_reg <= host_side_port_in[7];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks on the shared link
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   chk_bus_no_clash: assert property (!(port_d_oe && port_h_oe))
      else $error("both ends drive the bus");
   chk_dev_mem_only: assert property (port_d_oe |-> !mem_sel)
      else $error("device drives bus outside array access");
   chk_sel_clk_order: assert property ($fell(mem_sel) |-> !xfer_clk)
      else $error("select fell with clock high");
   chk_clk_high_width: assert property ($rose(xfer_clk) |-> xfer_clk [*5])
      else $error("clock high phase too short");
   chk_three_steps: assert property ($fell(mem_sel) |-> ##[44:46] $rose(mem_sel))
      else $error("array access not three steps long");
   chk_cmd_layout: assert property (rise && !mem_sel && rise_cnt_reg == 2'h0 |-> host_side_port_in[6:3] == 4'h0)
      else $error("first byte middle bits not zero");
   chk_read_answer: assert property (rise && !mem_sel && rise_cnt_reg == 2'h2 && rd_reg |-> ##[1:2] port_d_oe)
      else $error("read data not driven");
   chk_read_release: assert property ($fell(xfer_clk) && port_d_oe |-> ##[1:2] !port_d_oe)
      else $error("read data not released");
   chk_write_quiet: assert property (port_d_oe |-> rd_reg)
      else $error("device drives bus on a write");
   chk_bus_steady: assert property (xfer_clk |-> $stable(port_h_out) && $stable(port_h_oe))
      else $error("host bus moved while clock high");

   cover property (rise && !mem_sel && rise_cnt_reg == 2'h2 && rd_reg);
   cover property (rise && mem_sel);
   cover property ($rose(power_fail_out));
endmodule

/* File: verif/mnp_tb_top.sv */
`timescale 1ns/1ps
module mnp_tb_top;
   logic        clk_sys, arst_n, req_valid, req_write, ddr_valid, port_drive;
   logic        trip_level_select, req_ready, rsp_valid, power_fail_irq;
   logic [10:0] req_addr;
   logic [12:0] supply_mv;
   logic [7:0]  req_wdata, ddr_value, port_value, rsp_data;
   logic [7:0]  field_side_port_out, field_side_port_oe;
   int          err_count, checked, cycles;
   logic [10:0] addrs [4] = '{11'h000, 11'h7ff, 11'h100, 11'h0ff};
   logic [7:0]  datas [4] = '{8'h11, 8'hee, 8'h5c, 8'ha3};

   ////////////////////////////////////////////////////////////////////////////
   // the two ends facing each other, checker beside the link
   mnp_if u_mnp_if ();
   mnp_device u_mnp_device (.clk_sys(clk_sys), .arst_n(arst_n), .link(u_mnp_if.dev),
      .trip_level_select(trip_level_select), .supply_mv(supply_mv),
      .field_side_port_out(field_side_port_out), .field_side_port_oe(field_side_port_oe));
   mnp_host u_mnp_host (.clk_sys(clk_sys), .arst_n(arst_n), .link(u_mnp_if.host),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .ddr_valid(ddr_valid), .ddr_value(ddr_value), .port_value(port_value),
      .port_drive(port_drive), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .power_fail_irq(power_fail_irq));
   mnp_link_monitor u_mnp_link_monitor (.clk_sys(clk_sys), .arst_n(arst_n),
      .mem_sel(u_mnp_if.mem_sel), .xfer_clk(u_mnp_if.xfer_clk),
      .port_h_out(u_mnp_if.port_h_out), .port_h_oe(u_mnp_if.port_h_oe),
      .port_d_out(u_mnp_if.port_d_out), .port_d_oe(u_mnp_if.port_d_oe),
      .host_side_port_in(u_mnp_if.host_side_port_in), .power_fail_out(u_mnp_if.power_fail_out));

   ////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare, access and closing tasks
   task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      check8({7'h00, req_ready}, 8'h01, "ready");
   endtask

   task automatic access(input logic wr, input logic [10:0] a, input logic [7:0] d);
      wait_ready();
      req_write = wr;
      req_addr  = a;
      req_wdata = d;
      req_valid = 1'b1;
      @(negedge clk_sys);
      req_valid = 1'b0;
   endtask

   // read; mid-transfer look at the field outputs when mid is set
   task automatic rd(input logic [10:0] a, input logic [7:0] exp, input logic mid,
                     input logic [7:0] oe_exp, input logic [7:0] out_exp);
      int n;
      access(1'b0, a, 8'h00);
      if (mid) begin
         repeat (20) @(negedge clk_sys);
         check8(field_side_port_oe, oe_exp, "held oe");
         check8(field_side_port_out, out_exp, "held out");
      end
      n = 0;
      while (rsp_valid !== 1'b1 && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      check8({7'h00, rsp_valid}, 8'h01, "read answer");
      check8(rsp_data, exp, "read data");
   endtask

   task automatic ddr_write(input logic [7:0] v);
      wait_ready();
      ddr_value = v;
      ddr_valid = 1'b1;
      @(negedge clk_sys);
      ddr_valid = 1'b0;
      wait_ready();
      repeat (4) @(negedge clk_sys);
   endtask

   task automatic test_done();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {arst_n, req_valid, req_write, ddr_valid, port_drive, trip_level_select} = 6'h00;
      {req_addr, req_wdata, ddr_value, port_value} = 35'h0;
      supply_mv = 13'h1388;
      repeat (4) @(negedge clk_sys);
      check8({7'h00, u_mnp_if.power_fail_out}, 8'h00, "pf in reset");
      arst_n = 1'b1;
      // idle pass-through, last case undriven bus pulled up
      for (int i = 0; i < 3; i++) begin
         port_drive = (i < 2);
         port_value = datas[i];
         repeat (3) @(negedge clk_sys);
         check8(field_side_port_out, (i < 2) ? datas[i] : 8'hff, "idle out");
         check8(field_side_port_oe, 8'hff, "idle oe");
      end
      $display("test pass_through done");
      // back-to-back writes then reads at the address corners
      for (int i = 0; i < 4; i++) access(1'b1, addrs[i], datas[i]);
      for (int i = 0; i < 4; i++) rd(addrs[i], datas[i], 1'b0, 8'h00, 8'h00);
      $display("test array done");
      // direction register sets held or floating outputs during a transfer
      port_drive = 1'b1;
      port_value = 8'h3c;
      ddr_write(8'h0f);
      check8(field_side_port_oe, 8'hff, "idle after ddr");
      rd(addrs[1], datas[1], 1'b1, 8'h0f, 8'h3c);
      repeat (4) @(negedge clk_sys);
      ddr_write(8'h00);
      rd(addrs[2], datas[2], 1'b1, 8'h00, 8'h3c);
      $display("test direction done");
      // mid-run reset: direction register back to all driven, array kept
      arst_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      check8(field_side_port_oe, 8'h00, "oe in reset");
      arst_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      rd(addrs[3], datas[3], 1'b1, 8'hff, 8'h3c);
      $display("test reset done");
      // trip points at both tolerance settings, either side of threshold
      for (int i = 0; i < 4; i++) begin
         trip_level_select = i[1];
         supply_mv = (i < 2) ? 13'h128e - 13'h1 + i[0] : 13'h1194 - 13'h1 + i[0];
         repeat (3) @(negedge clk_sys);
         check8({7'h00, u_mnp_if.power_fail_out}, {7'h00, ~i[0]}, "pf level");
         check8({7'h00, power_fail_irq}, {7'h00, ~i[0]}, "pf irq");
      end
      $display("test power_fail done");
      test_done();
   end
endmodule
